// file: hdl/cgcr_pkg.sv
// constants, field layout and carrier types of the general control register group
package cgcr_pkg;

  // serial frame layout: read flag, 7-bit address, 8-bit data, msb first
  localparam int unsigned ADDR_W     = 7;
  localparam int unsigned DATA_W     = 8;
  localparam int unsigned FRAME_BITS = 16;

  // bit counter landmarks inside a frame
  localparam logic [4:0] CNT_FIRST = 5'h00;
  localparam logic [4:0] CNT_ADDR  = 5'h07;
  localparam logic [4:0] CNT_LAST  = 5'h0f;
  localparam logic [4:0] CNT_DONE  = 5'h10;

  // register byte addresses
  localparam logic [6:0] ADDR_DIV_INIT = 7'h71;
  localparam logic [6:0] ADDR_REACQ    = 7'h72;
  localparam logic [6:0] ADDR_BIAS_CAL = 7'h73;

  // field positions and reset values
  localparam int unsigned BIT_TRIGGER   = 7;
  localparam int unsigned BIT_READ_EDGE = 0;
  localparam logic        READ_EDGE_RST = 1'b0;
  localparam logic [7:0]  BYTE_ZERO     = 8'h00;

  // serial pins seen from the device, all synchronous to core_clk
  typedef struct packed {
    logic sclk;
    logic cs_n;
    logic serial_data_line_i;
  } cgcr_spi_in_t;

  typedef struct packed {
    logic serial_data_line_o;
    logic serial_data_line_oe;
  } cgcr_spi_out_t;

  // one-cycle command pulses towards the analog and divider logic
  typedef struct packed {
    logic div_init;
    logic reacquire;
    logic cal_start;
  } cgcr_ctrl_t;

  // a written byte asks for its action only when the trigger bit is one
  function automatic logic cgcr_trig(input logic [7:0] data);
    cgcr_trig = data[BIT_TRIGGER];
  endfunction

endpackage

// file: hdl/cgcr_bias_cal.sv
// bias calibration sequencer: busy flag held from start until the analog side reports done
module cgcr_bias_cal
  import cgcr_pkg::*;
(
  // clock and reset
  input  wire logic core_clk,
  input  wire logic resetn,
  // request from the register bank and completion from the bias cell
  input  wire logic start_req,
  input  wire logic cal_done,
  // towards the bias cell and the status read-back
  output logic      cal_start,
  output logic      cal_busy
);

  typedef enum logic {CAL_IDLE, CAL_RUN} cgcr_cal_state_t;

  cgcr_cal_state_t state_r;

  // a new request restarts the run even if done arrives in the same cycle
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      state_r   <= CAL_IDLE;
      cal_busy  <= 1'b0;
      cal_start <= 1'b0;
    end
    else
    begin
      cal_start <= start_req;  // RL4
      unique case (state_r)
        CAL_IDLE:
        begin
          if (start_req)
          begin
            state_r  <= CAL_RUN;
            cal_busy <= 1'b1;  // RL5
          end
        end
        CAL_RUN:
        begin
          if (!start_req && cal_done)
          begin
            state_r  <= CAL_IDLE;
            cal_busy <= 1'b0;  // RL5
          end
        end
      endcase
    end
  end

endmodule

// file: hdl/cgcr_regs.sv
// general control register group behind the 3-wire serial port
// Contract
// RL1 - a written one in the divider-init bit yields a one-cycle divider init pulse and the bit never stays set.
// RL2 - the host issues the divider-init write as part of its startup sequence.
// RL3 - a written one in the re-acquire bit yields a one-cycle re-lock pulse for the synthesizer loop and self-clears.
// RL4 - a written one in the bias calibration bit starts the bias calibration.
// RL5 - the bias calibration bit reads one while calibration runs and clears itself when it completes.
// RL6 - the host triggers bias calibration as part of its startup sequence.
// RL7 - the read edge bit, zero after reset, picks falling (0) or rising (1) serial clock edge for read data.
// RL8 - writing zero to a self-clearing bit does nothing, write-only bits read zero, reserved bits are written zero.
module cgcr_regs
  import cgcr_pkg::*;
(
  // clock and reset
  input  wire logic    core_clk,
  input  wire logic    resetn,
  // serial port pins
  input  cgcr_spi_in_t spi_in,
  output cgcr_spi_out_t spi_out,
  // bias cell completion
  input  wire logic    bias_cal_done,
  // control towards the clock core
  output cgcr_ctrl_t   ctrl_pulse,
  output logic         read_output_edge_select,
  output logic         bias_cal_busy
);

  logic        sclk_q_r;
  logic [4:0]  bit_cnt_r;
  logic [15:0] shift_in_r;
  logic        is_read_r;
  logic        rd_active_r;
  logic [7:0]  rd_shift_r;
  logic        serial_data_line_o_r;
  logic        serial_data_line_oe_r;
  logic        div_init_r;
  logic        reacq_r;
  logic        read_edge_r;
  logic        cal_start_w;

  logic        sclk_rise;
  logic        sclk_fall;
  logic        drive_edge;
  logic [15:0] shift_in_nxt;
  logic [6:0]  fr_addr;
  logic [7:0]  fr_data;
  logic [6:0]  rd_addr;
  logic [7:0]  rd_data;
  logic        wr_fire;
  logic        rd_load;
  logic        cal_req;
  logic [4:0]  release_cnt;

  // pins are synchronous, so one stage of history is enough for edge detection
  assign sclk_rise    = spi_in.sclk & ~sclk_q_r & ~spi_in.cs_n;
  assign sclk_fall    = ~spi_in.sclk & sclk_q_r & ~spi_in.cs_n;
  assign drive_edge   = read_edge_r ? sclk_rise : sclk_fall;  // RL7
  assign shift_in_nxt = {shift_in_r[14:0], spi_in.serial_data_line_i};
  assign fr_addr      = shift_in_nxt[14:8];
  assign fr_data      = shift_in_nxt[7:0];
  assign rd_addr      = shift_in_nxt[6:0];
  assign wr_fire      = sclk_rise && (bit_cnt_r == CNT_LAST) && !is_read_r;
  assign rd_load      = sclk_rise && (bit_cnt_r == CNT_ADDR) && is_read_r;
  assign cal_req      = wr_fire && (fr_addr == ADDR_BIAS_CAL) && cgcr_trig(fr_data);  // RL4
  // rising mode hands the line back on the 16th rise, falling mode on the fall after it
  assign release_cnt  = read_edge_r ? CNT_LAST : CNT_DONE;

  // read-back mux: write-only trigger bits and reserved bits read zero
  always_comb
  begin
    rd_data = BYTE_ZERO;  // RL8
    if (rd_addr == ADDR_BIAS_CAL)
    begin
      rd_data[BIT_TRIGGER]   = bias_cal_busy;  // RL5
      rd_data[BIT_READ_EDGE] = read_edge_r;
    end
  end

  // frame bookkeeping; extra clocks past 16 bits are ignored until chip select rises
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      sclk_q_r   <= 1'b0;
      bit_cnt_r  <= CNT_FIRST;
      shift_in_r <= 16'h0000;
      is_read_r  <= 1'b0;
    end
    else
    begin
      sclk_q_r <= spi_in.sclk;
      if (spi_in.cs_n)
      begin
        bit_cnt_r <= CNT_FIRST;
        is_read_r <= 1'b0;
      end
      else if (sclk_rise && (bit_cnt_r != CNT_DONE))
      begin
        bit_cnt_r  <= bit_cnt_r + 5'h01;
        shift_in_r <= shift_in_nxt;
        if (bit_cnt_r == CNT_FIRST)
        begin
          is_read_r <= spi_in.serial_data_line_i;
        end
      end
    end
  end

  // self-clearing command pulses; a written zero leaves them idle
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      div_init_r <= 1'b0;
      reacq_r    <= 1'b0;
    end
    else
    begin
      div_init_r <= wr_fire && (fr_addr == ADDR_DIV_INIT) && cgcr_trig(fr_data);  // RL1
      reacq_r    <= wr_fire && (fr_addr == ADDR_REACQ) && cgcr_trig(fr_data);  // RL3
    end
  end

  // read edge select is the only written bit of the group that keeps its value
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      read_edge_r <= READ_EDGE_RST;  // RL7
    end
    else if (wr_fire && (fr_addr == ADDR_BIAS_CAL))
    begin
      read_edge_r <= fr_data[BIT_READ_EDGE];  // RL7
    end
  end

  // read data shifter; the line is released at frame end or when chip select rises
  always_ff @(posedge core_clk)
  begin
    if (!resetn || spi_in.cs_n)
    begin
      rd_active_r <= 1'b0;
      rd_shift_r  <= BYTE_ZERO;
      serial_data_line_o_r    <= 1'b0;
      serial_data_line_oe_r   <= 1'b0;
    end
    else if (rd_load)
    begin
      rd_active_r <= 1'b1;
      if (read_edge_r)
      begin
        serial_data_line_o_r   <= rd_data[7];  // RL7
        rd_shift_r <= {rd_data[6:0], 1'b0};
        serial_data_line_oe_r  <= 1'b1;
      end
      else
      begin
        rd_shift_r <= rd_data;
      end
    end
    else if (drive_edge && rd_active_r)
    begin
      if (bit_cnt_r == release_cnt)
      begin
        rd_active_r <= 1'b0;
        serial_data_line_oe_r   <= 1'b0;
      end
      else
      begin
        serial_data_line_o_r   <= rd_shift_r[7];  // RL7
        rd_shift_r <= {rd_shift_r[6:0], 1'b0};
        serial_data_line_oe_r  <= 1'b1;
      end
    end
  end

  // calibration sequencing lives in its own small state machine
  cgcr_bias_cal u_bias_cal (
    .core_clk  (core_clk),
    .resetn    (resetn),
    .start_req (cal_req),
    .cal_done  (bias_cal_done),
    .cal_start (cal_start_w),
    .cal_busy  (bias_cal_busy)
  );

  assign spi_out.serial_data_line_o           = serial_data_line_o_r;
  assign spi_out.serial_data_line_oe          = serial_data_line_oe_r;
  assign ctrl_pulse.div_init      = div_init_r;
  assign ctrl_pulse.reacquire     = reacq_r;
  assign ctrl_pulse.cal_start     = cal_start_w;
  assign read_output_edge_select  = read_edge_r;

  // checks on the control group
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  AST_DIV_INIT_PULSE: assert property (  // RL1
    wr_fire && (fr_addr == ADDR_DIV_INIT) && fr_data[BIT_TRIGGER] |=> div_init_r ##1 !div_init_r)
    else $error("divider init pulse missing or too long");
  AST_REACQ_PULSE: assert property (  // RL3
    wr_fire && (fr_addr == ADDR_REACQ) && fr_data[BIT_TRIGGER] |=> reacq_r ##1 !reacq_r)
    else $error("re-acquire pulse missing or too long");
  AST_ZERO_NO_EFFECT: assert property (  // RL8
    wr_fire && !fr_data[BIT_TRIGGER] && (fr_addr != ADDR_BIAS_CAL) |=> !div_init_r && !reacq_r)
    else $error("written zero produced a command pulse");
  AST_CAL_START: assert property (  // RL4
    cal_req |=> cal_start_w && bias_cal_busy)
    else $error("calibration did not start");
  AST_CAL_HOLD: assert property (  // RL5
    bias_cal_busy && !bias_cal_done |=> bias_cal_busy)
    else $error("calibration busy dropped before done");
  AST_CAL_CLEAR: assert property (  // RL5
    bias_cal_busy && bias_cal_done && !cal_req |=> !bias_cal_busy)
    else $error("calibration busy not cleared on done");
  AST_EDGE_WRITE: assert property (  // RL7
    wr_fire && (fr_addr == ADDR_BIAS_CAL) |=> read_edge_r == $past(fr_data[BIT_READ_EDGE]))
    else $error("read edge select not written");
  AST_RISE_ONLY: assert property (  // RL7
    serial_data_line_oe_r && read_edge_r && !sclk_rise |=> $stable(serial_data_line_o_r) || !serial_data_line_oe_r)
    else $error("read data moved off the rising edge");
  AST_FALL_ONLY: assert property (  // RL7
    serial_data_line_oe_r && !read_edge_r && !sclk_fall |=> $stable(serial_data_line_o_r) || !serial_data_line_oe_r)
    else $error("read data moved off the falling edge");
  AST_WO_READ_ZERO: assert property (  // RL8
    rd_load && (rd_addr != ADDR_BIAS_CAL) |=> rd_shift_r == BYTE_ZERO && !serial_data_line_o_r)
    else $error("write-only register read nonzero");

  COV_DIV_INIT: cover property (div_init_r);
  COV_CAL_DONE: cover property (bias_cal_busy ##1 !bias_cal_busy);
  COV_READ_RISE: cover property (rd_load && read_edge_r);
  COV_READ_FALL: cover property (rd_load && !read_edge_r);

endmodule

// file: testbench/cgcr_spi_host_model.sv
// spi host model framing register accesses on the 3-wire port
module cgcr_spi_host_model
  import cgcr_pkg::*;
(
  // clock
  input  wire logic     core_clk,
  // serial pins
  output cgcr_spi_in_t  spi_in,
  input  cgcr_spi_out_t spi_out,
  // captured read byte for the monitor
  output logic [7:0]    rd_byte,
  output logic          rd_stb
);
  timeunit 1ns;
  timeprecision 1ps;
  logic sclk_r  = 1'b0;
  logic cs_n_r  = 1'b1;
  logic drv_oe  = 1'b0;
  logic drv_bit = 1'b0;
  logic line;

  initial rd_byte = 8'h00;
  initial rd_stb = 1'b0;

  // data line has a pull-up, so a released line reads one
  assign line = drv_oe ? drv_bit : (spi_out.serial_data_line_oe ? spi_out.serial_data_line_o : 1'b1);
  assign spi_in = {sclk_r, cs_n_r, line};

  // one frame msb first; sclk stands low between frames
  task automatic frame(input logic [15:0] w, input int half, input logic edge_sel);
    logic [7:0] d;
    d = 8'h00;
    cs_n_r <= 1'b0;
    for (int i = 15; i >= 0; i--)
    begin
      drv_oe  <= !(w[15] && i < 8); // let go while the device answers
      drv_bit <= w[i];
      repeat (half) @(posedge core_clk);
      if (w[15] && !edge_sel && i < 8) d[i] = line;
      sclk_r <= 1'b1;
      @(posedge core_clk);
      // rising mode drives right after the last address bit, so let go once it is taken
      if (w[15] && i == 8) drv_oe <= 1'b0;
      repeat (half - 1) @(posedge core_clk);
      if (w[15] && edge_sel && i > 0 && i < 9) d[i-1] = line;
      sclk_r <= 1'b0;
    end
    repeat (half) @(posedge core_clk);
    cs_n_r  <= 1'b1;
    drv_oe  <= 1'b0;
    rd_byte <= d;
    rd_stb  <= w[15];
    @(posedge core_clk);
    rd_stb  <= 1'b0;
  endtask
endmodule

// file: testbench/testbench.sv
// self-checking bench for the general control register group
module testbench
  import cgcr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic          core_clk      = 1'b0;
  logic          resetn        = 1'b0;
  logic          bias_cal_done = 1'b0;
  cgcr_spi_in_t  spi_in;
  cgcr_spi_out_t spi_out;
  cgcr_ctrl_t    ctrl_pulse;
  logic          read_output_edge_select;
  logic          bias_cal_busy;
  logic [7:0]    rd_byte;
  logic          rd_stb;
  logic [8:0]    exp_q[$];
  logic [8:0]    mon_exp;
  logic [6:0]    a;
  logic          edge_exp = 1'b0;
  logic          busy_exp = 1'b0;
  int            half = 3;
  int            n_errors = 0;
  int            checks_done = 0;
  int            cycles = 0;

  cgcr_regs u_cgcr_regs (.core_clk(core_clk), .resetn(resetn), .spi_in(spi_in),
    .spi_out(spi_out), .bias_cal_done(bias_cal_done), .ctrl_pulse(ctrl_pulse),
    .read_output_edge_select(read_output_edge_select), .bias_cal_busy(bias_cal_busy));
  cgcr_spi_host_model u_host (.core_clk(core_clk), .spi_in(spi_in), .spi_out(spi_out),
    .rd_byte(rd_byte), .rd_stb(rd_stb));

  // 125 MHz core clock
  initial forever #4 core_clk = ~core_clk;

  task automatic check(input logic [8:0] seen, input logic [8:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // a write notes the pulse it must cause before the frame goes out
  task automatic wr(input logic [6:0] ad, input logic [7:0] d);
    if (d[7] && ad == ADDR_DIV_INIT) exp_q.push_back(9'h004);
    if (d[7] && ad == ADDR_REACQ) exp_q.push_back(9'h002);
    if (ad == ADDR_BIAS_CAL)
    begin
      edge_exp = d[0];
      if (d[7]) exp_q.push_back(9'h001);
      busy_exp = busy_exp | d[7];
    end
    u_host.frame({1'b0, ad, d}, half, edge_exp);
  endtask

  task automatic rd(input logic [6:0] ad);
    exp_q.push_back({1'b1, (ad == ADDR_BIAS_CAL) ? {busy_exp, 6'h00, edge_exp} : BYTE_ZERO});
    u_host.frame({1'b1, ad, 8'h00}, half, edge_exp);
  endtask

  // bias cell reports completion with a one-cycle pulse
  task automatic finish_cal();
    bias_cal_done <= 1'b1;
    @(posedge core_clk);
    bias_cal_done <= 1'b0;
    busy_exp = 1'b0;
    @(posedge core_clk);
  endtask

  // monitor: each pulse or read byte retires the oldest note
  always @(posedge core_clk)
  begin
    cycles++;
    if (resetn && (ctrl_pulse != 3'b000 || rd_stb))
    begin
      mon_exp = (exp_q.size() > 0) ? exp_q.pop_front() : 9'h1ff;
      check(rd_stb ? {1'b1, rd_byte} : {6'h00, ctrl_pulse}, mon_exp);
    end
    if (cycles > 20000)
    begin
      n_errors++;
      give_verdict();
    end
  end

  // main sequence
  initial
  begin
    void'($urandom(82));
    repeat (4) @(posedge core_clk);
    resetn <= 1'b1;
    @(posedge core_clk);
    check({4'h0, ctrl_pulse, read_output_edge_select, bias_cal_busy}, 9'h000);
    // startup order: dividers first, then bias calibration
    wr(ADDR_DIV_INIT, 8'h80);
    wr(ADDR_BIAS_CAL, 8'h80);
    rd(ADDR_BIAS_CAL);
    finish_cal();
    rd(ADDR_BIAS_CAL);
    // zeros start nothing; write-only and unmapped places read zero
    wr(ADDR_DIV_INIT, 8'h00);
    wr(ADDR_REACQ, 8'h00);
    wr(ADDR_REACQ, 8'h80);
    rd(ADDR_DIV_INIT);
    rd(ADDR_REACQ);
    rd(7'h70);
    wr(ADDR_BIAS_CAL, 8'h01);
    check({8'h00, read_output_edge_select}, 9'h001);
    rd(ADDR_BIAS_CAL);
    // random mix of registers, speeds and edge choices
    repeat (24)
    begin
      half = 3 + ($urandom % 3);
      a = ADDR_DIV_INIT + 7'($urandom % 3);
      wr(a, {1'($urandom), 6'h00, (a == ADDR_BIAS_CAL) ? 1'($urandom) : 1'b0});
      rd(ADDR_BIAS_CAL);
      if (busy_exp) finish_cal();
    end
    repeat (4) @(posedge core_clk);
    check(9'(exp_q.size()), 9'h000);
    give_verdict();
  end
endmodule
